//--- rtl/lpca_pkg.sv
// Shared constants for the light/proximity configuration and alert block
package lpca_pkg;
  // Register offsets
  localparam logic [3:0] LPCA_ADDR_RSVD   = 4'h0;
  localparam logic [3:0] LPCA_ADDR_CFG    = 4'h1;
  localparam logic [3:0] LPCA_ADDR_ALERT  = 4'h2;
  localparam logic [3:0] LPCA_ADDR_PLT    = 4'h3;
  localparam logic [3:0] LPCA_ADDR_PHT    = 4'h4;
  localparam logic [3:0] LPCA_ADDR_ATH1   = 4'h5;
  localparam logic [3:0] LPCA_ADDR_ATH2   = 4'h6;
  localparam logic [3:0] LPCA_ADDR_ATH3   = 4'h7;
  localparam logic [3:0] LPCA_ADDR_PDATA  = 4'h8;
  localparam logic [3:0] LPCA_ADDR_ADATA1 = 4'h9;
  localparam logic [3:0] LPCA_ADDR_ADATA2 = 4'ha;
  // Reset values
  localparam logic [7:0] LPCA_RST_CFG    = 8'h00;
  localparam logic [7:0] LPCA_RST_ALERT  = 8'h00;
  localparam logic [7:0] LPCA_RST_PLT    = 8'h00;
  localparam logic [7:0] LPCA_RST_PHT    = 8'hff;
  localparam logic [7:0] LPCA_RST_ATH1   = 8'h00;
  localparam logic [7:0] LPCA_RST_ATH2   = 8'hf0;
  localparam logic [7:0] LPCA_RST_ATH3   = 8'hff;
  localparam logic [7:0] LPCA_RST_DATA   = 8'h00;
  localparam logic [7:0] LPCA_RSVD_VALUE = 8'h00;
  // Configuration field positions
  localparam int LPCA_CFG_PROX_EN  = 7;
  localparam int LPCA_CFG_SLP_HI   = 6;
  localparam int LPCA_CFG_SLP_LO   = 4;
  localparam int LPCA_CFG_DRIVE    = 3;
  localparam int LPCA_CFG_AMB_EN   = 2;
  localparam int LPCA_CFG_RANGE    = 1;
  localparam int LPCA_CFG_SPECTRUM = 0;
  // Alert control field positions
  localparam int LPCA_AL_PFLAG    = 7;
  localparam int LPCA_AL_PPRST_HI = 6;
  localparam int LPCA_AL_PPRST_LO = 5;
  localparam int LPCA_AL_UNUSED   = 4;
  localparam int LPCA_AL_AFLAG    = 3;
  localparam int LPCA_AL_APRST_HI = 2;
  localparam int LPCA_AL_APRST_LO = 1;
  localparam int LPCA_AL_COMBINE  = 0;
  // Timing, in ns, and derived cycle counts at 125 MHz
  localparam longint LPCA_CLK_NS        = 8;
  localparam longint LPCA_PROX_CONV_NS  = 540000;
  localparam longint LPCA_SLEEP_UNIT_NS = 12500000;
  localparam longint LPCA_AMB_PERIOD_NS = 100000000;
  localparam logic [31:0] LPCA_PROX_CONV_CYC =
    32'((LPCA_PROX_CONV_NS + LPCA_CLK_NS - 1) / LPCA_CLK_NS);
  localparam logic [31:0] LPCA_SLEEP_UNIT_CYC =
    32'((LPCA_SLEEP_UNIT_NS + LPCA_CLK_NS - 1) / LPCA_CLK_NS);
  localparam logic [31:0] LPCA_AMB_PERIOD_CYC =
    32'((LPCA_AMB_PERIOD_NS + LPCA_CLK_NS - 1) / LPCA_CLK_NS);
  // Persistence: counts needed per code
  localparam logic [4:0] LPCA_PRST_N0 = 5'd1;
  localparam logic [4:0] LPCA_PRST_N1 = 5'd4;
  localparam logic [4:0] LPCA_PRST_N2 = 5'd8;
  localparam logic [4:0] LPCA_PRST_N3 = 5'd16;
  typedef enum logic [1:0] {LPCA_P_IDLE, LPCA_P_CONV, LPCA_P_SLEEP} lpca_pstate_t;
endpackage

//--- rtl/lpca_persist.sv
// Consecutive-trip persistence counter for one event flag
`timescale 1ns/1ns
module lpca_persist
  import lpca_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       conv_done,
  input  wire logic       trip,
  input  wire logic [1:0] sel,
  output logic            fire
);
  logic [4:0] cnt_r;
  logic [4:0] need;
  logic [4:0] cnt_inc;

  always_comb begin
    case (sel)
      2'b00:   need = LPCA_PRST_N0;
      2'b01:   need = LPCA_PRST_N1;
      2'b10:   need = LPCA_PRST_N2;
      default: need = LPCA_PRST_N3;
    endcase
  end

  // Saturates at the largest count so a long run keeps firing
  assign cnt_inc = (cnt_r == LPCA_PRST_N3) ? cnt_r : cnt_r + 5'd1;
  assign fire    = conv_done && trip && (cnt_inc >= need);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'd0;
    end else if (conv_done) begin
      cnt_r <= trip ? cnt_inc : 5'd0;
    end
  end
endmodule

//--- rtl/lpca_top.sv
// Configuration, conversion scheduling and alert logic of the light/proximity sensor
// Notes on behaviour
// - Proximity enable off stops sensing; on converts continuously, first result after 0.54ms.
// - Sleep codes 111/110/101/100 give 0, 12.5, 50, 75 ms between LED pulses.
// - Sleep codes 011/010/001/000 give 100, 200, 400, 800 ms; 000 at reset.
// - LED drive bit picks 110mA when clear, 220mA when set.
// - Ambient enable off stops sensing; on gives a new result every 100ms.
// - Ambient range bit selects low-lux at 0, high-lux at 1.
// - Spectrum bit selects visible data at 0, infrared data at 1.
// - Proximity flag bit 7 is sticky; set by event, cleared only by writing 0.
// - Proximity persistence bits 6:5 need 1, 4, 8 or 16 trips.
// - Ambient flag bit 3 is sticky; set by event, cleared only by writing 0.
// - Ambient persistence bits 2:1 need 1, 4, 8 or 16 out-of-window results.
// - Combine bit 0 drives alert low when either flag is set.
// - Combine bit 1 drives alert low only when both flags are set.
// - Register 0x00 is reserved, read-only, content meaningless.
// - Proximity compared to 8-bit low/high thresholds, reset 0x00 and 0xFF.
// - Ambient window uses 12-bit thresholds in registers 0x05 to 0x07.
// - Each proximity result lands in read-only register 0x08, reset 0x00.
`timescale 1ns/1ns
module lpca_top
  import lpca_pkg::*;
#(
  parameter logic [31:0] PROX_CONV_CYC  = LPCA_PROX_CONV_CYC,
  parameter logic [31:0] SLEEP_UNIT_CYC = LPCA_SLEEP_UNIT_CYC,
  parameter logic [31:0] AMB_PERIOD_CYC = LPCA_AMB_PERIOD_CYC
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd_en,
  output logic [7:0]       reg_rdata,
  input  wire logic [7:0]  prox_adc_data,
  input  wire logic [11:0] amb_adc_data,
  output logic             led_pulse,
  output logic             led_drive_high,
  output logic             amb_convert,
  output logic             amb_range_high,
  output logic             amb_spectrum_ir,
  output logic             alert_out,
  output logic             alert_oe
);
  logic [7:0]   cfg_r;
  logic [7:0]   alert_r;
  logic [7:0]   plt_r;
  logic [7:0]   pht_r;
  logic [7:0]   ath1_r;
  logic [7:0]   ath2_r;
  logic [7:0]   ath3_r;
  logic [7:0]   pdata_r;
  logic [11:0]  adata_r;
  logic [7:0]   rdata_r;
  lpca_pstate_t pstate_r;
  logic [31:0]  pcnt_r;
  logic [31:0]  acnt_r;
  logic         led_pulse_r;
  logic         alert_oe_r;
  logic         prox_end;
  logic         amb_end;
  logic         prox_trip;
  logic         amb_trip;
  logic         prox_fire;
  logic         amb_fire;
  logic         alert_wr;
  logic         alert_cond;
  logic [31:0]  sleep_cyc;
  function automatic logic outside(input logic [11:0] v, input logic [11:0] lo,
                                   input logic [11:0] hi);
    outside = (v < lo) || (v > hi);
  endfunction
  function automatic logic [31:0] sleep_units(input logic [2:0] code);
    case (code)
      3'b111:  sleep_units = 32'd0;
      3'b110:  sleep_units = 32'd1;
      3'b101:  sleep_units = 32'd4;
      3'b100:  sleep_units = 32'd6;
      3'b011:  sleep_units = 32'd8;
      3'b010:  sleep_units = 32'd16;
      3'b001:  sleep_units = 32'd32;
      default: sleep_units = 32'd64;
    endcase
  endfunction
  assign sleep_cyc = 32'(sleep_units(cfg_r[LPCA_CFG_SLP_HI:LPCA_CFG_SLP_LO]) * SLEEP_UNIT_CYC);
  assign prox_end  = (pstate_r == LPCA_P_CONV) && (pcnt_r == PROX_CONV_CYC - 32'd1);
  assign amb_end   = cfg_r[LPCA_CFG_AMB_EN] && (acnt_r == AMB_PERIOD_CYC - 32'd1);
  assign prox_trip = outside({4'h0, prox_adc_data}, {4'h0, plt_r}, {4'h0, pht_r});
  assign amb_trip  = outside(amb_adc_data, {ath2_r[3:0], ath1_r},
                             {ath3_r, ath2_r[7:4]});
  assign alert_wr  = reg_wr_en && (reg_addr == LPCA_ADDR_ALERT);
  assign alert_cond = alert_r[LPCA_AL_COMBINE] ?
                      (alert_r[LPCA_AL_PFLAG] && alert_r[LPCA_AL_AFLAG]) :
                      (alert_r[LPCA_AL_PFLAG] || alert_r[LPCA_AL_AFLAG]);
  // Writable configuration and threshold registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_r  <= LPCA_RST_CFG;
      plt_r  <= LPCA_RST_PLT;
      pht_r  <= LPCA_RST_PHT;
      ath1_r <= LPCA_RST_ATH1;
      ath2_r <= LPCA_RST_ATH2;
      ath3_r <= LPCA_RST_ATH3;
    end else if (reg_wr_en) begin
      case (reg_addr)
        LPCA_ADDR_CFG:  cfg_r  <= reg_wdata;
        LPCA_ADDR_PLT:  plt_r  <= reg_wdata;
        LPCA_ADDR_PHT:  pht_r  <= reg_wdata;
        LPCA_ADDR_ATH1: ath1_r <= reg_wdata;
        LPCA_ADDR_ATH2: ath2_r <= reg_wdata;
        LPCA_ADDR_ATH3: ath3_r <= reg_wdata;
        default: ;
      endcase
    end
  end
  // Alert control: flags set by events, cleared by writing 0; set wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alert_r <= LPCA_RST_ALERT;
    end else begin
      if (alert_wr) begin
        alert_r[6:4] <= reg_wdata[6:4];
        alert_r[2:0] <= reg_wdata[2:0];
      end
      if (prox_fire) begin
        alert_r[LPCA_AL_PFLAG] <= 1'b1;
      end else if (alert_wr && !reg_wdata[LPCA_AL_PFLAG]) begin
        alert_r[LPCA_AL_PFLAG] <= 1'b0;
      end
      if (amb_fire) begin
        alert_r[LPCA_AL_AFLAG] <= 1'b1;
      end else if (alert_wr && !reg_wdata[LPCA_AL_AFLAG]) begin
        alert_r[LPCA_AL_AFLAG] <= 1'b0;
      end
    end
  end
  lpca_persist u_prox_persist (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .conv_done (prox_end),
    .trip      (prox_trip),
    .sel       (alert_r[LPCA_AL_PPRST_HI:LPCA_AL_PPRST_LO]),
    .fire      (prox_fire)
  );
  lpca_persist u_amb_persist (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .conv_done (amb_end),
    .trip      (amb_trip),
    .sel       (alert_r[LPCA_AL_APRST_HI:LPCA_AL_APRST_LO]),
    .fire      (amb_fire)
  );
  // Proximity scheduler: convert with LED, then sleep
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pstate_r <= LPCA_P_IDLE;
      pcnt_r   <= 32'd0;
    end else if (!cfg_r[LPCA_CFG_PROX_EN]) begin
      pstate_r <= LPCA_P_IDLE;
      pcnt_r   <= 32'd0;
    end else begin
      case (pstate_r)
        LPCA_P_IDLE: begin
          pstate_r <= LPCA_P_CONV;
          pcnt_r   <= 32'd0;
        end
        LPCA_P_CONV: begin
          if (prox_end) begin
            pstate_r <= (sleep_cyc == 32'd0) ? LPCA_P_CONV : LPCA_P_SLEEP;
            pcnt_r   <= 32'd0;
          end else begin
            pcnt_r <= pcnt_r + 32'd1;
          end
        end
        LPCA_P_SLEEP: begin
          if (pcnt_r >= sleep_cyc - 32'd1) begin
            pstate_r <= LPCA_P_CONV;
            pcnt_r   <= 32'd0;
          end else begin
            pcnt_r <= pcnt_r + 32'd1;
          end
        end
        default: begin
          pstate_r <= LPCA_P_IDLE;
          pcnt_r   <= 32'd0;
        end
      endcase
    end
  end
  // Ambient period counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acnt_r <= 32'd0;
    end else if (!cfg_r[LPCA_CFG_AMB_EN] || amb_end) begin
      acnt_r <= 32'd0;
    end else begin
      acnt_r <= acnt_r + 32'd1;
    end
  end
  // Result registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pdata_r <= LPCA_RST_DATA;
      adata_r <= {4'h0, LPCA_RST_DATA};
    end else begin
      if (prox_end) begin
        pdata_r <= prox_adc_data;
      end
      if (amb_end) begin
        adata_r <= amb_adc_data;
      end
    end
  end
  // Pin-facing flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      led_pulse_r <= 1'b0;
      alert_oe_r  <= 1'b0;
    end else begin
      led_pulse_r <= (pstate_r == LPCA_P_CONV) && cfg_r[LPCA_CFG_PROX_EN];
      alert_oe_r  <= alert_cond;
    end
  end
  // Register read port
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        LPCA_ADDR_RSVD:   rdata_r <= LPCA_RSVD_VALUE;
        LPCA_ADDR_CFG:    rdata_r <= cfg_r;
        LPCA_ADDR_ALERT:  rdata_r <= alert_r;
        LPCA_ADDR_PLT:    rdata_r <= plt_r;
        LPCA_ADDR_PHT:    rdata_r <= pht_r;
        LPCA_ADDR_ATH1:   rdata_r <= ath1_r;
        LPCA_ADDR_ATH2:   rdata_r <= ath2_r;
        LPCA_ADDR_ATH3:   rdata_r <= ath3_r;
        LPCA_ADDR_PDATA:  rdata_r <= pdata_r;
        LPCA_ADDR_ADATA1: rdata_r <= adata_r[7:0];
        LPCA_ADDR_ADATA2: rdata_r <= {4'h0, adata_r[11:8]};
        default:          rdata_r <= 8'h00;
      endcase
    end
  end
  assign reg_rdata       = rdata_r;
  assign led_pulse       = led_pulse_r;
  assign led_drive_high  = cfg_r[LPCA_CFG_DRIVE];
  assign amb_convert     = cfg_r[LPCA_CFG_AMB_EN];
  assign amb_range_high  = cfg_r[LPCA_CFG_RANGE];
  assign amb_spectrum_ir = cfg_r[LPCA_CFG_SPECTRUM];
  assign alert_out       = 1'b0;
  assign alert_oe        = alert_oe_r;
  sequence s_prox_single_trip;
    prox_end && prox_trip && (alert_r[6:5] == 2'b00);
  endsequence
  sequence s_flag_clear;
    alert_wr && !reg_wdata[LPCA_AL_PFLAG] && !prox_fire;
  endsequence

  a_prox_off_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_r[LPCA_CFG_PROX_EN] |=> !led_pulse) else $error("led pulse while prox off");
  a_prox_first_conv: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(pstate_r == LPCA_P_CONV) && $past(pstate_r) == LPCA_P_IDLE |-> pcnt_r == 32'd0)
    else $error("first conversion not counted from zero");
  a_fastest_sleep: assert property (@(posedge ref_clk) disable iff (rst)
    prox_end && cfg_r[6:4] == 3'b111 && cfg_r[7] |=> pstate_r == LPCA_P_CONV)
    else $error("zero sleep did not restart conversion");
  a_long_sleep: assert property (@(posedge ref_clk) disable iff (rst)
    prox_end && cfg_r[6:4] != 3'b111 && cfg_r[7] |=> pstate_r == LPCA_P_SLEEP)
    else $error("sleep phase skipped");
  a_amb_off_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_r[LPCA_CFG_AMB_EN] |=> $stable(adata_r)) else $error("ambient result while off");
  a_prox_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
    s_prox_single_trip |=> alert_r[LPCA_AL_PFLAG]) else $error("prox flag not set");
  a_prox_flag_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    alert_r[LPCA_AL_PFLAG] && !(alert_wr && !reg_wdata[LPCA_AL_PFLAG])
    |=> alert_r[LPCA_AL_PFLAG]) else $error("prox flag dropped");
  a_prox_flag_clear: assert property (@(posedge ref_clk) disable iff (rst)
    s_flag_clear |=> !alert_r[LPCA_AL_PFLAG]) else $error("prox flag not cleared");
  a_amb_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
    amb_end && amb_trip && alert_r[2:1] == 2'b00 |=> alert_r[LPCA_AL_AFLAG])
    else $error("ambient flag not set");
  a_alert_or: assert property (@(posedge ref_clk) disable iff (rst)
    !alert_r[0] && (alert_r[7] || alert_r[3]) |=> alert_oe) else $error("or alert missing");
  a_alert_and: assert property (@(posedge ref_clk) disable iff (rst)
    alert_r[0] && !(alert_r[7] && alert_r[3]) |=> !alert_oe) else $error("and alert wrong");
  a_alert_release: assert property (@(posedge ref_clk) disable iff (rst)
    !alert_r[7] && !alert_r[3] |=> !alert_oe) else $error("alert held without flags");
  a_rsvd_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd_en && reg_addr == LPCA_ADDR_RSVD |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  a_pdata_latch: assert property (@(posedge ref_clk) disable iff (rst)
    prox_end |=> pdata_r == $past(prox_adc_data)) else $error("prox result not stored");
endmodule

//--- bench/lpca_host.sv
// Register-port host model standing in for the serial bus master
`timescale 1ns/1ns
module lpca_host
  import lpca_pkg::*;
(
  input  wire logic       ref_clk,
  output logic [3:0]      reg_addr,
  output logic            reg_wr_en,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd_en,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 4'h0;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end

  // Strobe held across one rising edge; idle lines show inverted junk
  task automatic write(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = (a == LPCA_ADDR_ALERT) ? (d & 8'hef) : d;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic read(input logic [3:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
endmodule

//--- bench/light_prox_config_and_alert_tb.sv
// Register-level testbench of the light/proximity configuration and alert block
`timescale 1ns/1ns
module light_prox_config_and_alert_tb
  import lpca_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr;
  logic        reg_wr_en;
  logic [7:0]  reg_wdata;
  logic        reg_rd_en;
  logic [7:0]  reg_rdata;
  logic [7:0]  prox_adc_data = 8'h5a;
  logic [11:0] amb_adc_data = 12'h950;
  logic        led_pulse;
  logic        led_drive_high;
  logic        amb_convert;
  logic        amb_range_high;
  logic        amb_spectrum_ir;
  logic        alert_out;
  logic        alert_oe;
  int          err_count = 0;
  int          checks_done = 0;
  int          n;
  int          cnt;
  logic        expf;
  logic [7:0]  v;
  logic [3:0]  ra [12] = '{LPCA_ADDR_RSVD, LPCA_ADDR_CFG, LPCA_ADDR_ALERT, LPCA_ADDR_PLT,
                           LPCA_ADDR_PHT, LPCA_ADDR_ATH1, LPCA_ADDR_ATH2, LPCA_ADDR_ATH3,
                           LPCA_ADDR_PDATA, LPCA_ADDR_ADATA1, LPCA_ADDR_ADATA2, 4'hb};
  logic [7:0]  rv [12] = '{LPCA_RSVD_VALUE, LPCA_RST_CFG, LPCA_RST_ALERT, LPCA_RST_PLT,
                           LPCA_RST_PHT, LPCA_RST_ATH1, LPCA_RST_ATH2, LPCA_RST_ATH3,
                           LPCA_RST_DATA, LPCA_RST_DATA, LPCA_RST_DATA, 8'h00};
  int          units [8] = '{64, 32, 16, 8, 6, 4, 1, 0};
  int          need [4] = '{1, 4, 8, 16};

  always #4 ref_clk = ~ref_clk;

  lpca_top #(.PROX_CONV_CYC(32'd8), .SLEEP_UNIT_CYC(32'd4), .AMB_PERIOD_CYC(32'd20)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .prox_adc_data(prox_adc_data), .amb_adc_data(amb_adc_data), .led_pulse(led_pulse),
    .led_drive_high(led_drive_high), .amb_convert(amb_convert),
    .amb_range_high(amb_range_high), .amb_spectrum_ir(amb_spectrum_ir),
    .alert_out(alert_out), .alert_oe(alert_oe));

  lpca_host i_host (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata));

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp1(input string what, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic cmpn(input string what, input int e, input int g);
    checks_done++;
    if (g != e) begin
      err_count++;
      $display("BAD %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic do_reset();
    @(negedge ref_clk);
    rst = 1'b1;
    cyc(4);
    rst = 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.read(a, d);
    cmp8(what, e, d);
  endtask

  // Cycles until the LED pulse reaches the given level, bounded
  task automatic wait_pulse(input logic lvl, output int k);
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (led_pulse !== lvl && k < 400);
    if (led_pulse !== lvl) begin
      err_count++;
      $display("BAD led_pulse wait ran out");
      conclude();
    end
  endtask

  initial begin
    do_reset();
    // Reset values, reserved and unmapped places
    for (int i = 0; i < 12; i++) rd_chk("reset value", ra[i], rv[i]);
    cmp1("alert_oe", 1'b0, alert_oe);
    cmp1("alert_out", 1'b0, alert_out);
    $display("Test reset values done");
    // Configuration outputs and read-only places
    i_host.write(LPCA_ADDR_CFG, 8'h0f);
    i_host.write(LPCA_ADDR_PDATA, 8'h77);
    i_host.write(LPCA_ADDR_RSVD, 8'h55);
    cmp8("config pins", 8'h0f, {4'h0, led_drive_high, amb_convert, amb_range_high,
         amb_spectrum_ir});
    rd_chk("cfg", LPCA_ADDR_CFG, 8'h0f);
    rd_chk("pdata ro", LPCA_ADDR_PDATA, 8'h00);
    rd_chk("reserved", LPCA_ADDR_RSVD, 8'h00);
    expf = 1'b0;
    for (int i = 0; i < 50; i++) begin
      cyc(1);
      expf = expf | led_pulse;
    end
    cmp1("led idle", 1'b0, expf);
    i_host.write(LPCA_ADDR_CFG, 8'h00);
    cyc(2);
    cmp8("config pins", 8'h00, {4'h0, led_drive_high, amb_convert, amb_range_high,
         amb_spectrum_ir});
    $display("Test configuration done");
    // Conversion length and sleep gap for sleep codes 000 to 110, back to back for 111
    for (int c = 0; c < 8; c++) begin
      i_host.write(LPCA_ADDR_CFG, 8'h80 | 8'(c << 4));
      wait_pulse(1'b1, n);
      if (c == 7) begin
        expf = 1'b1;
        for (int i = 0; i < 24; i++) begin
          cyc(1);
          expf = expf & led_pulse;
        end
        cmp1("back to back", 1'b1, expf);
      end else begin
        wait_pulse(1'b0, n);
        cmpn("conversion cycles", 8, n);
        wait_pulse(1'b1, n);
        cmpn("sleep cycles", units[c] * 4, n);
        if (c == 0) rd_chk("first result", LPCA_ADDR_PDATA, 8'h5a);
      end
      i_host.write(LPCA_ADDR_CFG, 8'h00);
      cyc(2);
      cmp1("led stop", 1'b0, led_pulse);
    end
    $display("Test sleep codes done");
    // Proximity persistence with one non-tripping result at conversion 2
    for (int p = 0; p < 4; p++) begin
      do_reset();
      i_host.write(LPCA_ADDR_PHT, 8'h80);
      i_host.write(LPCA_ADDR_ALERT, 8'(p << 5));
      prox_adc_data = 8'hf8;
      i_host.write(LPCA_ADDR_CFG, 8'h80);
      cnt = 0;
      expf = 1'b0;
      for (int k = 1; k <= need[p] + 3; k++) begin
        wait_pulse(1'b1, n);
        wait_pulse(1'b0, n);
        cnt = (k == 2) ? 0 : cnt + 1;
        expf = expf | (cnt >= need[p]);
        cyc(4);
        rd_chk("prox flag", LPCA_ADDR_ALERT, {expf, 2'(p), 5'h00});
        cmp1("alert_oe or", expf, alert_oe);
        prox_adc_data = (k == 1) ? 8'h40 : 8'hf8;
      end
      i_host.write(LPCA_ADDR_CFG, 8'h00);
      i_host.write(LPCA_ADDR_ALERT, 8'(p << 5));
      cyc(3);
      cmp1("alert released", 1'b0, alert_oe);
      rd_chk("prox flag clear", LPCA_ADDR_ALERT, 8'(p << 5));
    end
    $display("Test proximity persistence done");
    // Ambient persistence with a window of 0x100 to 0x800
    for (int p = 0; p < 4; p++) begin
      do_reset();
      i_host.write(LPCA_ADDR_ATH2, 8'h01);
      i_host.write(LPCA_ADDR_ATH3, 8'h80);
      i_host.write(LPCA_ADDR_ALERT, 8'(p << 1));
      i_host.write(LPCA_ADDR_CFG, 8'h04);
      cyc(need[p] * 20 - 8);
      rd_chk("amb flag early", LPCA_ADDR_ALERT, 8'(p << 1));
      cyc(16);
      rd_chk("amb flag", LPCA_ADDR_ALERT, 8'h08 | 8'(p << 1));
    end
    rd_chk("amb low", LPCA_ADDR_ADATA1, 8'h50);
    rd_chk("amb high", LPCA_ADDR_ADATA2, 8'h09);
    $display("Test ambient persistence done");
    // Flag combination
    cmp1("or ambient only", 1'b1, alert_oe);
    i_host.write(LPCA_ADDR_ALERT, 8'h0f);
    cyc(3);
    cmp1("and ambient only", 1'b0, alert_oe);
    i_host.write(LPCA_ADDR_PHT, 8'h80);
    prox_adc_data = 8'hf8;
    i_host.write(LPCA_ADDR_ALERT, 8'h09);
    i_host.write(LPCA_ADDR_CFG, 8'h84);
    wait_pulse(1'b1, n);
    wait_pulse(1'b0, n);
    cyc(3);
    cmp1("and both", 1'b1, alert_oe);
    i_host.write(LPCA_ADDR_CFG, 8'h00);
    i_host.write(LPCA_ADDR_ALERT, 8'h81);
    cyc(3);
    cmp1("and prox only", 1'b0, alert_oe);
    rd_chk("alert reg", LPCA_ADDR_ALERT, 8'h81);
    i_host.write(LPCA_ADDR_ALERT, 8'h80);
    cyc(3);
    cmp1("or prox only", 1'b1, alert_oe);
    $display("Test flag combination done");
    conclude();
  end
endmodule
